/* File: hw/gpio_port_pkg.sv */
// Constants for one general purpose I/O port: register byte offsets,
// reset values of the per-pin fields and the power state encoding.
// Assumes a byte-addressed register port with 32-bit data.
package gpio_port_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SEL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SEL0_SET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SEL0_CLR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_OE_SET = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OE_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OUT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_OUT_SET = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_OUT_CLR = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IN = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_POL = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_IN_EN = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN_SET = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN_CLR = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_PEND = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_PEND_CLR = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_WAKE = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_WAKE_SET = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_WAKE_CLR = 8'h54;
  localparam logic [ADDR_W-1:0] OFS_DUAL = 8'h5C;
  localparam logic [ADDR_W-1:0] OFS_PAD_A = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_PAD_B = 8'h64;
  localparam logic [ADDR_W-1:0] OFS_SEL1 = 8'h68;
  localparam logic [ADDR_W-1:0] OFS_SEL1_SET = 8'h6C;
  localparam logic [ADDR_W-1:0] OFS_SEL1_CLR = 8'h70;
  localparam logic [ADDR_W-1:0] OFS_SEL2 = 8'h74;
  localparam logic [ADDR_W-1:0] OFS_SEL2_SET = 8'h78;
  localparam logic [ADDR_W-1:0] OFS_SEL2_CLR = 8'h7C;
  localparam logic [ADDR_W-1:0] OFS_DS0 = 8'hB0;
  localparam logic [ADDR_W-1:0] OFS_DS1 = 8'hB4;
  localparam logic [ADDR_W-1:0] OFS_PS = 8'hB8;
  localparam logic [ADDR_W-1:0] OFS_VSSEL = 8'hC0;

  // Per-pin reset values
  localparam logic RST_SEL0 = 1'b1;
  localparam logic RST_IN_EN = 1'b1;
  localparam logic RST_CLR = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // Power state reported by the power manager
  typedef enum logic [1:0] {
    pwr_full_run,
    pwr_light,
    deep_low_power_state,
    retention_low_power_state
  } power_state_t;

endpackage

/* File: hw/gpio_port.sv */
// One general purpose I/O port: register file with set/clear aliases,
// pin input capture, level/edge interrupt detection, pending status,
// the port interrupt output and the pin wake request.
// Assumes pin inputs asynchronous to clock and a single-cycle register
// port whose read data stands in the cycle after the read strobe.
//
// Overview of operation
// [RULE_01] Detect only in I/O mode with input enabled
// [RULE_02] Per-pin enable, level or edge, polarity
// [RULE_03] Pending sets regardless; enabled pending raises irq
// [RULE_04] Disabling enable keeps pending bits
// [RULE_05] Writing one to clear drops pending
// [RULE_06] Polarity zero high/rising, one low/falling
// [RULE_07] Dual-edge flags both transitions
// [RULE_08] Clear also re-arms the edge detector
// [RULE_09] Port irq ORs enabled pending bits
// [RULE_10] Low-power wake only from edges, asynchronously
// [RULE_11] Wake events merge into shared wake request
// [RULE_12] Software clears pending, then sets sequencer enable
// [RULE_13] Power manager field gates wake, set last
// [RULE_14] Light/deep port irq needs wake and irq enable
// [RULE_15] Full run shared wake needs both enables
// [RULE_16] Light-state wake needs deep then full run
// [RULE_17] Software enables pin interrupt as last step
// [RULE_18] Handler reads, services, clears, ends interrupt
// [RULE_19] Every field resets on any reset
// [RULE_20] Set and clear aliases touch addressed bits
// [RULE_21] Three select bits choose function or I/O
// [RULE_22] Input register shows pin only when enabled
// [RULE_23] Reset: I/O mode, input on, outputs off
// [RULE_24] Synchronise inputs; separate wake edge compare
// [RULE_25] Unimplemented pins ignore writes; set beats clear
//
// Added by the designer: the strobed register port.

`timescale 1ns/10ps
`default_nettype none

module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int NUM_PINS = 32
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] io_mode,
  output logic [NUM_PINS-1:0] af_select_lo,
  output logic [NUM_PINS-1:0] af_select_hi,
  output logic [NUM_PINS-1:0] pad_pull_a,
  output logic [NUM_PINS-1:0] pad_pull_b,
  output logic [NUM_PINS-1:0] drive_lo,
  output logic [NUM_PINS-1:0] drive_hi,
  output logic [NUM_PINS-1:0] pull_strength,
  output logic [NUM_PINS-1:0] pad_supply,
  input wire power_state_t power_state,
  input wire logic [NUM_PINS-1:0] power_sequencer_pin_wake_enable,
  input wire logic power_manager_pin_wake_field,
  output logic per_port_irq,
  output logic pin_wake_req
);

  typedef struct packed {
    logic [NUM_PINS-1:0] sel0;
    logic [NUM_PINS-1:0] sel1;
    logic [NUM_PINS-1:0] sel2;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] mode;
    logic [NUM_PINS-1:0] pol;
    logic [NUM_PINS-1:0] in_en;
    logic [NUM_PINS-1:0] irq_en;
    logic [NUM_PINS-1:0] pending;
    logic [NUM_PINS-1:0] wake_en;
    logic [NUM_PINS-1:0] dual;
    logic [NUM_PINS-1:0] pad_a;
    logic [NUM_PINS-1:0] pad_b;
    logic [NUM_PINS-1:0] ds0;
    logic [NUM_PINS-1:0] ds1;
    logic [NUM_PINS-1:0] ps;
    logic [NUM_PINS-1:0] vssel;
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] prev;
    logic [DATA_W-1:0] rdata;
  } state_t;

  localparam logic [NUM_PINS-1:0] ONES = {NUM_PINS{1'b1}};
  localparam logic [NUM_PINS-1:0] ZEROS = {NUM_PINS{1'b0}};

  state_t state_q;
  state_t state_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [NUM_PINS-1:0] wdata;
  logic [NUM_PINS-1:0] armed;
  logic [NUM_PINS-1:0] rise;
  logic [NUM_PINS-1:0] fall;
  logic [NUM_PINS-1:0] level_hit;
  logic [NUM_PINS-1:0] edge_hit;
  logic [NUM_PINS-1:0] event_hit;
  logic [NUM_PINS-1:0] pend_clr;
  logic [NUM_PINS-1:0] enabled;
  logic [NUM_PINS-1:0] raw_rise;
  logic [NUM_PINS-1:0] raw_fall;
  logic [NUM_PINS-1:0] async_edge;
  logic run_wake;
  logic sleep_wake;

  // Base write, set alias or clear alias of one register
  function automatic logic [NUM_PINS-1:0] upd(
    input logic [NUM_PINS-1:0] cur,
    input logic [ADDR_W-1:0] base,
    input logic [ADDR_W-1:0] set_ofs,
    input logic [ADDR_W-1:0] clr_ofs,
    input logic wr,
    input logic [ADDR_W-1:0] addr,
    input logic [NUM_PINS-1:0] wd
  );
    logic [NUM_PINS-1:0] r;
    r = cur;
    if (wr && addr == base) begin
      r = wd;
    end else if (wr && addr == set_ofs) begin
      r = cur | wd; // [RULE_20]
    end else if (wr && addr == clr_ofs) begin
      r = cur & ~wd; // [RULE_20]
    end
    return r;
  endfunction

  // Plain read-write register with no aliases
  function automatic logic [NUM_PINS-1:0] upd_rw(
    input logic [NUM_PINS-1:0] cur,
    input logic [ADDR_W-1:0] base,
    input logic wr,
    input logic [ADDR_W-1:0] addr,
    input logic [NUM_PINS-1:0] wd
  );
    logic [NUM_PINS-1:0] r;
    r = cur;
    if (wr && addr == base) begin
      r = wd;
    end
    return r;
  endfunction

  // Widen a per-pin vector to the data bus, upper bits zero
  function automatic logic [DATA_W-1:0] ext(
    input logic [NUM_PINS-1:0] v
  );
    logic [DATA_W-1:0] r;
    r = RDATA_ZERO;
    r[NUM_PINS-1:0] = v;
    return r;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // Only the implemented pin positions take write data
  assign wdata = reg_wdata[NUM_PINS-1:0]; // [RULE_25]

  // Event detection on the synchronised pin level
  always_comb begin
    armed = state_q.sel0 & state_q.in_en; // [RULE_01]
    rise = state_q.sync2 & ~state_q.prev;
    fall = ~state_q.sync2 & state_q.prev;
    level_hit = state_q.sync2 ^ state_q.pol; // [RULE_06]
    edge_hit = (state_q.dual & (rise | fall)) // [RULE_07]
      | (~state_q.dual & ~state_q.pol & rise) // [RULE_06]
      | (~state_q.dual & state_q.pol & fall); // [RULE_06]
    event_hit = armed & ((state_q.mode & edge_hit) // [RULE_02]
      | (~state_q.mode & level_hit)); // [RULE_02]
  end

  // Write-one-to-clear strobe for pending bits
  always_comb begin
    pend_clr = ZEROS;
    if (reg_write && reg_addr == OFS_PEND_CLR) begin
      pend_clr = wdata; // [RULE_05]
    end
  end

  // Next state of registers, synchronisers and read data
  always_comb begin
    state_d = state_q;
    state_d.sel0 = upd(state_q.sel0, OFS_SEL0, OFS_SEL0_SET,
      OFS_SEL0_CLR, reg_write, reg_addr, wdata);
    state_d.sel1 = upd(state_q.sel1, OFS_SEL1, OFS_SEL1_SET,
      OFS_SEL1_CLR, reg_write, reg_addr, wdata);
    state_d.sel2 = upd(state_q.sel2, OFS_SEL2, OFS_SEL2_SET,
      OFS_SEL2_CLR, reg_write, reg_addr, wdata);
    state_d.oe = upd(state_q.oe, OFS_OE, OFS_OE_SET,
      OFS_OE_CLR, reg_write, reg_addr, wdata);
    state_d.out = upd(state_q.out, OFS_OUT, OFS_OUT_SET,
      OFS_OUT_CLR, reg_write, reg_addr, wdata);
    state_d.irq_en = upd(state_q.irq_en, OFS_IRQ_EN,
      OFS_IRQ_EN_SET, OFS_IRQ_EN_CLR, reg_write, reg_addr,
      wdata); // [RULE_04]
    state_d.wake_en = upd(state_q.wake_en, OFS_WAKE,
      OFS_WAKE_SET, OFS_WAKE_CLR, reg_write, reg_addr, wdata);
    state_d.mode = upd_rw(state_q.mode, OFS_MODE, reg_write,
      reg_addr, wdata);
    state_d.pol = upd_rw(state_q.pol, OFS_POL, reg_write,
      reg_addr, wdata);
    state_d.in_en = upd_rw(state_q.in_en, OFS_IN_EN, reg_write,
      reg_addr, wdata);
    state_d.dual = upd_rw(state_q.dual, OFS_DUAL, reg_write,
      reg_addr, wdata);
    state_d.pad_a = upd_rw(state_q.pad_a, OFS_PAD_A, reg_write,
      reg_addr, wdata);
    state_d.pad_b = upd_rw(state_q.pad_b, OFS_PAD_B, reg_write,
      reg_addr, wdata);
    state_d.ds0 = upd_rw(state_q.ds0, OFS_DS0, reg_write,
      reg_addr, wdata);
    state_d.ds1 = upd_rw(state_q.ds1, OFS_DS1, reg_write,
      reg_addr, wdata);
    state_d.ps = upd_rw(state_q.ps, OFS_PS, reg_write,
      reg_addr, wdata);
    state_d.vssel = upd_rw(state_q.vssel, OFS_VSSEL, reg_write,
      reg_addr, wdata);
    // Pending: a new event wins over a clear in the same cycle
    state_d.pending = (state_q.pending & ~pend_clr) // [RULE_05]
      | event_hit; // [RULE_03] [RULE_25]
    // Two-flop synchroniser, then the edge reference
    state_d.sync1 = pin_in; // [RULE_24]
    state_d.sync2 = state_q.sync1; // [RULE_24]
    // Edge reference follows the synchronised level every cycle, so
    // a falling edge is seen again after a high level; a clear
    // re-arms the detector on the present level
    state_d.prev = (state_q.sync2 & pend_clr) // [RULE_08]
      | (state_q.sync2 & ~pend_clr);
    // Read data for the cycle after the strobe
    state_d.rdata = RDATA_ZERO;
    if (reg_read) begin
      unique case (reg_addr)
        OFS_SEL0: state_d.rdata = ext(state_q.sel0);
        OFS_OE: state_d.rdata = ext(state_q.oe);
        OFS_OUT: state_d.rdata = ext(state_q.out);
        OFS_IN: state_d.rdata =
          ext(state_q.sync2 & state_q.in_en); // [RULE_22]
        OFS_MODE: state_d.rdata = ext(state_q.mode);
        OFS_POL: state_d.rdata = ext(state_q.pol);
        OFS_IN_EN: state_d.rdata = ext(state_q.in_en);
        OFS_IRQ_EN: state_d.rdata = ext(state_q.irq_en);
        OFS_PEND: state_d.rdata = ext(state_q.pending);
        OFS_WAKE: state_d.rdata = ext(state_q.wake_en);
        OFS_DUAL: state_d.rdata = ext(state_q.dual);
        OFS_PAD_A: state_d.rdata = ext(state_q.pad_a);
        OFS_PAD_B: state_d.rdata = ext(state_q.pad_b);
        OFS_SEL1: state_d.rdata = ext(state_q.sel1);
        OFS_SEL2: state_d.rdata = ext(state_q.sel2);
        OFS_DS0: state_d.rdata = ext(state_q.ds0);
        OFS_DS1: state_d.rdata = ext(state_q.ds1);
        OFS_PS: state_d.rdata = ext(state_q.ps);
        OFS_VSSEL: state_d.rdata = ext(state_q.vssel);
        default: state_d.rdata = RDATA_ZERO;
      endcase
    end
  end

  // State register; one reset returns every field
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0; // [RULE_19]
      state_q.sel0 <= {NUM_PINS{RST_SEL0}}; // [RULE_23]
      state_q.sel1 <= {NUM_PINS{RST_CLR}}; // [RULE_23]
      state_q.sel2 <= {NUM_PINS{RST_CLR}}; // [RULE_23]
      state_q.in_en <= {NUM_PINS{RST_IN_EN}}; // [RULE_23]
      state_q.oe <= {NUM_PINS{RST_CLR}}; // [RULE_23]
      state_q.irq_en <= {NUM_PINS{RST_CLR}}; // [RULE_23]
    end else begin
      state_q <= state_d;
    end
  end

  // Port interrupt per power state
  always_comb begin
    enabled = state_q.pending & state_q.irq_en; // [RULE_09]
    per_port_irq = 1'b0;
    unique case (power_state)
      pwr_full_run: per_port_irq = |enabled; // [RULE_09]
      pwr_light,
      deep_low_power_state:
        per_port_irq = |(enabled & state_q.wake_en); // [RULE_14]
      retention_low_power_state: per_port_irq = 1'b0;
    endcase
  end

  // Wake request: clocked pending edges in full run, raw pin
  // compare against the held reference while the clock stops
  always_comb begin
    raw_rise = pin_in & ~state_q.prev;
    raw_fall = ~pin_in & state_q.prev;
    async_edge = armed & state_q.mode // [RULE_10]
      & power_sequencer_pin_wake_enable // [RULE_12]
      & ((state_q.dual & (raw_rise | raw_fall))
      | (~state_q.dual & ~state_q.pol & raw_rise)
      | (~state_q.dual & state_q.pol & raw_fall));
    run_wake = |(state_q.pending & state_q.mode
      & power_sequencer_pin_wake_enable); // [RULE_15]
    sleep_wake = |async_edge; // [RULE_10] [RULE_24]
    pin_wake_req = 1'b0;
    if (power_manager_pin_wake_field) begin // [RULE_13]
      if (power_state == pwr_full_run) begin
        pin_wake_req = run_wake; // [RULE_11] [RULE_15]
      end else begin
        pin_wake_req = sleep_wake | run_wake; // [RULE_11]
      end
    end
  end

  // Pin and pad outputs straight from registers, except pin_oe which is gated by sel0
  assign reg_rdata = state_q.rdata;
  assign pin_out = state_q.out;
  assign pin_oe = state_q.oe & state_q.sel0; // [RULE_21]
  assign io_mode = state_q.sel0; // [RULE_21]
  assign af_select_lo = state_q.sel1; // [RULE_21]
  assign af_select_hi = state_q.sel2; // [RULE_21]
  assign pad_pull_a = state_q.pad_a;
  assign pad_pull_b = state_q.pad_b;
  assign drive_lo = state_q.ds0;
  assign drive_hi = state_q.ds1;
  assign pull_strength = state_q.ps;
  assign pad_supply = state_q.vssel;

endmodule // gpio_port

`default_nettype wire

/* File: sim/gpio_port_checker.sv */
// Checker for gpio_port: register port, alias and interrupt relations.
// Assumes one clock domain; bound to every gpio_port instance.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_checker
  import gpio_port_pkg::*;
#(
  parameter int NUM_PINS = 32
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] io_mode,
  input wire power_state_t power_state,
  input wire logic power_manager_pin_wake_field,
  input wire logic per_port_irq,
  input wire logic pin_wake_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Write data trimmed to the implemented pins
  logic [NUM_PINS-1:0] wd;
  assign wd = reg_wdata[NUM_PINS-1:0];
  // Register port and alias behaviour
  a_rdata_upper_zero: assert property ((reg_rdata >> NUM_PINS) == '0)
    else $error("read data above the pin count");
  a_alias_read_zero: assert property (reg_read && (reg_addr == OFS_PEND_CLR
    || reg_addr == OFS_IRQ_EN_SET) |=> reg_rdata == '0)
    else $error("alias read returned data");
  a_mode_set_alias: assert property (reg_write && reg_addr == OFS_SEL0_SET
    |=> io_mode == ($past(io_mode) | $past(wd)))
    else $error("set alias wrong on mode select");
  a_out_clear_alias: assert property (reg_write && reg_addr == OFS_OUT_CLR
    |=> pin_out == ($past(pin_out) & ~$past(wd)))
    else $error("clear alias wrong on output level");
  a_ctrl_hold_idle: assert property (!$past(reg_write)
    |-> $stable(pin_out) && $stable(pin_oe))
    else $error("output control moved without a write");
  a_oe_needs_io: assert property ((pin_oe & ~io_mode) == '0)
    else $error("output driven while pin is in alternate mode");
  // Interrupt and wake gating
  a_irq_en_clear: assert property (reg_write && reg_addr == OFS_IRQ_EN_CLR
    && (&wd) |=> !per_port_irq)
    else $error("port interrupt stayed with all enables cleared");
  a_irq_retention_off: assert property
    (power_state == retention_low_power_state |-> !per_port_irq)
    else $error("port interrupt in retention state");
  a_wake_gated_off: assert property
    (!power_manager_pin_wake_field |-> !pin_wake_req)
    else $error("wake request without manager field");
  // Main scenarios reached
  c_irq: cover property (per_port_irq);
  c_deep_wake: cover property
    (pin_wake_req && power_state == deep_low_power_state);
  c_pend_clear: cover property (reg_write && reg_addr == OFS_PEND_CLR);
endmodule // gpio_port_checker

bind gpio_port gpio_port_checker #(.NUM_PINS(NUM_PINS)) chk_u (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .io_mode(io_mode), .power_state(power_state),
  .power_manager_pin_wake_field(power_manager_pin_wake_field),
  .per_port_irq(per_port_irq), .pin_wake_req(pin_wake_req));
`default_nettype wire

/* File: sim/gpio_pin_model.sv */
// Far-side model: external pin levels and an interrupt line watcher.
// Assumes the bench names wanted levels; pins move just after an edge.
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_model #(
  parameter int N = 16
) (
  input wire logic clock,
  input wire logic [N-1:0] want,
  input wire logic irq,
  output logic [N-1:0] pins,
  output var int irq_seen
);
  logic irq_q;
  // Start quiet
  initial begin
    pins = '0;
    irq_q = 1'b0;
    irq_seen = 0;
  end
  // Drive pins after the edge and count interrupt rises
  always @(posedge clock) begin
    pins <= want;
    irq_q <= irq;
    if (irq && !irq_q) begin
      irq_seen <= irq_seen + 1;
    end
  end
endmodule // gpio_pin_model
`default_nettype wire

/* File: sim/gpio_port_tb_top.sv */
// Bench for gpio_port: registers, pin events and power state gating.
// Assumes a 125 MHz clock and the pin model as the far side.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_tb_top;
  import gpio_port_pkg::*;
  localparam int NP = 16;
  logic clock, resetn, reg_write, reg_read, field, wake, irq;
  logic m, p, du, s, e, x;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [NP-1:0] want, pins, seq_en;
  power_state_t ps;
  int irq_seen, n_checks, num_errors;
  logic [5:0] tc [9] = '{6'b100011, 6'b110010, 6'b110101, 6'b100100,
    6'b101101, 6'b111011, 6'b000111, 6'b010110, 6'b010001};
  logic [7:0] zr [6] = '{OFS_OE, OFS_OUT, OFS_MODE, OFS_POL, OFS_IRQ_EN,
    OFS_PEND};
  logic [7:0] br [7] = '{OFS_OE, OFS_OUT, OFS_IRQ_EN, OFS_WAKE, OFS_SEL1,
    OFS_SEL2, OFS_SEL0};

  gpio_port #(.NUM_PINS(NP)) dut_u (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pin_in(pins), .pin_out(), .pin_oe(),
    .io_mode(), .af_select_lo(), .af_select_hi(), .pad_pull_a(),
    .pad_pull_b(), .drive_lo(), .drive_hi(), .pull_strength(),
    .pad_supply(), .power_state(ps),
    .power_sequencer_pin_wake_enable(seq_en),
    .power_manager_pin_wake_field(field), .per_port_irq(irq),
    .pin_wake_req(wake));
  gpio_pin_model #(.N(NP)) pins_u (.clock(clock), .want(want), .irq(irq),
    .pins(pins), .irq_seen(irq_seen));

  // 8 ns clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] ex, gt);
    n_checks++;
    if (gt !== ex) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, ex, gt);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One write cycle, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
    input string nm);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(nm, ex, reg_rdata);
    @(posedge clock);
  endtask
  // Low then high on pin 0, each held past the input synchroniser
  task automatic tog();
    want <= 16'h0000;
    cyc(6);
    want <= 16'h0001;
    cyc(6);
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    num_errors++;
    summarize();
  end

  // Test sequence
  initial begin
    {resetn, reg_write, reg_read, field} = 4'h0;
    {reg_addr, reg_wdata, want, seq_en} = '0;
    ps = pwr_full_run;
    n_checks = 0;
    num_errors = 0;
    cyc(20);
    resetn <= 1'b1;
    cyc(3);
    rd(OFS_SEL0, 32'h0000_FFFF, "sel0_reset");
    rd(OFS_IN_EN, 32'h0000_FFFF, "in_en_reset");
    foreach (zr[i]) rd(zr[i], 32'h0, "zero_reset");
    wr(8'h44, 32'h0000_FFFF);
    rd(8'h44, 32'h0, "unmapped");
    rd(OFS_PEND_CLR, 32'h0, "clear_alias_read");
    wr(OFS_OUT, 32'hFFFF_FFFF);
    rd(OFS_OUT, 32'h0000_FFFF, "upper_bits");
    tend("reset_map");
    foreach (br[i]) begin
      wr(br[i], 32'h0000_00F0);
      wr(br[i] + 8'h04, 32'h0000_0003);
      rd(br[i], 32'h0000_00F3, "set_alias");
      wr(br[i] + 8'h08, 32'h0000_0030);
      rd(br[i], 32'h0000_00C3, "clear_alias");
      wr(br[i], (br[i] == OFS_SEL0) ? 32'h0000_FFFF : 32'h0);
    end
    rd(OFS_IRQ_EN_SET, 32'h0, "set_alias_read");
    tend("aliases");
    want <= 16'hA5C3;
    cyc(6);
    wr(OFS_IN, 32'h0);
    rd(OFS_IN, 32'h0000_A5C3, "input_level");
    wr(OFS_IN_EN, 32'h0000_00FF);
    rd(OFS_IN, 32'h0000_00C3, "input_gated");
    wr(OFS_IN_EN, 32'h0000_FFFF);
    want <= 16'h0000;
    cyc(6);
    wr(OFS_PEND_CLR, 32'h0000_FFFF);
    tend("input");
    foreach (tc[i]) begin
      {m, p, du, s, e, x} = tc[i];
      wr(OFS_IRQ_EN, 32'h0);
      want <= {15'h0, s};
      cyc(6);
      wr(OFS_MODE, {31'h0, m});
      wr(OFS_POL, {31'h0, p});
      wr(OFS_DUAL, {31'h0, du});
      wr(OFS_PEND_CLR, 32'h1);
      wr(OFS_IRQ_EN_SET, 32'h1);
      want <= {15'h0, e};
      cyc(6);
      rd(OFS_PEND, {31'h0, x}, "pending");
      chk("port_irq", {31'h0, x}, {31'h0, irq});
    end
    chk("irq_rises", 32'd6, irq_seen);
    wr(OFS_IRQ_EN_CLR, 32'h0000_FFFF);
    rd(OFS_PEND, 32'h1, "pending_kept");
    chk("irq_disabled", 32'h0, {31'h0, irq});
    tend("events");
    wr(OFS_MODE, 32'h1);
    wr(OFS_POL, 32'h0);
    wr(OFS_DUAL, 32'h0);
    wr(OFS_PEND_CLR, 32'h0);
    rd(OFS_PEND, 32'h1, "clear_zero");
    wr(OFS_PEND_CLR, 32'h1);
    rd(OFS_PEND, 32'h0, "clear_one");
    tog();
    wr(OFS_PEND_CLR, 32'h1);
    tog();
    rd(OFS_PEND, 32'h1, "rearmed");
    wr(OFS_PEND_CLR, 32'h1);
    wr(OFS_SEL0_CLR, 32'h1);
    tog();
    rd(OFS_PEND, 32'h0, "alt_mode_quiet");
    wr(OFS_SEL0_SET, 32'h1);
    wr(OFS_IN_EN, 32'h0000_FFFE);
    tog();
    rd(OFS_PEND, 32'h0, "input_off_quiet");
    wr(OFS_IN_EN, 32'h0000_FFFF);
    tog();
    wr(OFS_IRQ_EN_SET, 32'h1);
    tend("clear_rearm");
    ps <= pwr_light;
    #1 chk("light_no_wake_en", 32'h0, {31'h0, irq});
    wr(OFS_WAKE_SET, 32'h1);
    #1 chk("light_wake_en", 32'h1, {31'h0, irq});
    ps <= retention_low_power_state;
    #1 chk("retention_irq", 32'h0, {31'h0, irq});
    ps <= pwr_full_run;
    seq_en <= 16'h0001;
    #1 chk("wake_no_field", 32'h0, {31'h0, wake});
    field <= 1'b1;
    #1 chk("wake_full_run", 32'h1, {31'h0, wake});
    tend("power_gating");
    ps <= deep_low_power_state;
    want <= 16'h0000;
    cyc(6);
    wr(OFS_PEND_CLR, 32'h1);
    #1 chk("wake_idle", 32'h0, {31'h0, wake});
    want <= 16'h0001;
    @(posedge clock);
    #1 chk("wake_async", 32'h1, {31'h0, wake});
    cyc(6);
    rd(OFS_PEND, 32'h1, "wake_source");
    wr(OFS_MODE, 32'h0);
    wr(OFS_PEND_CLR, 32'h1);
    cyc(3);
    rd(OFS_PEND, 32'h1, "level_pending");
    #1 chk("level_no_wake", 32'h0, {31'h0, wake});
    ps <= pwr_full_run;
    @(posedge clock);
    ps <= pwr_light;
    #1 chk("light_after_deep", 32'h1, {31'h0, irq});
    ps <= pwr_full_run;
    tend("wake");
    summarize();
  end
endmodule // gpio_port_tb_top
`default_nettype wire
